/* File: i2c_slave_bus.sv */
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_params.svh"

module i2c_slave_bus
   import i2c_slave_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic scl_oe,
   output logic sda_out,
   output logic sda_oe,
   input wire logic port_enable,
   input wire logic [1:0] slave_mode_select,
   input wire logic hold_time_select,
   input wire logic start_irq_enable,
   input wire logic stop_irq_enable,
   input wire logic address_hold_enable,
   input wire logic data_hold_enable,
   input wire logic ack_data,
   input wire logic [7:0] own_address,
   input wire logic [7:0] own_address_low,
   input wire logic [7:0] tx_data,
   input wire logic clock_release,
   input wire logic rx_read,
   input wire logic irq_clear,
   input wire logic overflow_clear,
   input wire logic collision_clear,
   output logic [7:0] receive_buffer,
   output logic buffer_full,
   output logic receive_overflow,
   output logic port_irq_flag,
   output logic ack_status,
   output logic ack_time,
   output logic rw_status,
   output logic prior_match,
   output logic bus_active,
   output logic start_seen,
   output logic stop_seen,
   output logic bus_collision
);

   // =======================================================================
   // Pin sampling
   logic [1:0] pins_s;
   logic scl_s;
   logic sda_s;

   bit_sync #(.WIDTH(2)) u_sync (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .din({scl_in, sda_in}),
      .dout(pins_s)
   );
   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   // =======================================================================
   // State
   state_t state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] shift_q, shift_d;
   logic [7:0] tx_q, tx_d;
   logic [7:0] rbuf_q, rbuf_d;
   logic [`HOLD_CNT_W-1:0] hold_q, hold_d;
   logic scl_p_q, scl_p_d;
   logic sda_p_q, sda_p_d;
   logic low_q, low_d;
   logic active_q, active_d;
   logic sseen_q, sseen_d;
   logic pseen_q, pseen_d;
   logic want_q, want_d;
   logic stretch_q, stretch_d;
   logic ackpend_q, ackpend_d;
   logic ackok_q, ackok_d;
   logic sda_oe_q, sda_oe_d;
   logic scl_oe_q, scl_oe_d;
   logic sda_out_q, sda_out_d;
   logic scl_out_q, scl_out_d;
   logic bf_q, bf_d;
   logic ov_q, ov_d;
   logic irq_q, irq_d;
   logic ackst_q, ackst_d;
   logic acktm_q, acktm_d;
   logic rw_q, rw_d;
   logic prior_q, prior_d;
   logic coll_q, coll_d;

   // =======================================================================
   // Bus conditions
   logic scl_rise, scl_fall, start_det, stop_det, start_acc;
   logic byte_done, ack_end, room, ten_bit, sp_irq;
   logic match7, match_hi, match_lo;

   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;
   assign start_det = port_enable & scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_det = port_enable & scl_s & scl_p_q & ~sda_p_q & sda_s
                     & low_q;
   // A Start seen inside one SCL high window is no Restart.
   assign start_acc = start_det & (~active_q | low_q);
   assign byte_done = active_q & scl_fall & (cnt_q == `BIT_LAST);
   assign ack_end = active_q & scl_fall & (cnt_q == `BIT_ACK);
   assign room = ~bf_q & ~ov_q;
   assign ten_bit = slave_mode_select[`MODE_TEN_BIT];
   assign sp_irq = slave_mode_select[`MODE_SP_IRQ];
   assign match7 = shift_q[7:1] == own_address[7:1];
   assign match_hi = (shift_q[7:3] == `TEN_PREFIX)
                     && (shift_q[2:1] == own_address[2:1]);
   assign match_lo = shift_q == own_address_low;

   // =======================================================================
   // Next-state logic
   logic take, sw_hold, irq_set, load, ov_set, coll_set;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      tx_d = tx_q;
      rbuf_d = rbuf_q;
      scl_p_d = scl_s;
      sda_p_d = sda_s;
      low_d = low_q;
      active_d = active_q;
      sseen_d = sseen_q;
      pseen_d = pseen_q;
      want_d = want_q;
      stretch_d = stretch_q;
      ackpend_d = ackpend_q;
      ackok_d = ackok_q;
      ackst_d = ackst_q;
      acktm_d = acktm_q;
      rw_d = rw_q;
      prior_d = prior_q;
      take = 1'b0;
      sw_hold = 1'b0;
      irq_set = 1'b0;
      load = 1'b0;
      ov_set = 1'b0;
      coll_set = 1'b0;

      if (active_q && !scl_s) begin
         low_d = 1'b1;
      end

      if (active_q && scl_rise && (cnt_q < `BIT_ACK)) begin
         cnt_d = cnt_q + 4'h1;
         if (cnt_q < `BIT_LAST) begin
            shift_d = {shift_q[6:0], sda_s};
         end else begin
            ackst_d = sda_s;
         end
      end

      if (state_q == ST_TX && scl_rise && cnt_q < `BIT_LAST
          && tx_q[7] && !sda_s) begin
         coll_set = 1'b1;
         state_d = ST_WAIT;
         want_d = 1'b0;
      end

      if (state_q == ST_TX && scl_fall && cnt_q != `RST_CNT
          && cnt_q < `BIT_LAST) begin
         tx_d = {tx_q[6:0], 1'b0};
         want_d = ~tx_q[6];
      end

      if (byte_done) begin
         case (state_q)
            ST_ADDR: begin
               sw_hold = address_hold_enable;
               if (!ten_bit) begin
                  if (match7) begin
                     take = 1'b1;
                     rw_d = shift_q[0];
                     state_d = shift_q[0] ? ST_TX : ST_RX;
                  end else begin
                     state_d = ST_WAIT;
                  end
               end else if (!match_hi) begin
                  prior_d = 1'b0;
                  state_d = ST_WAIT;
               end else if (!shift_q[0]) begin
                  prior_d = 1'b0;
                  take = 1'b1;
                  rw_d = 1'b0;
                  state_d = ST_ADDR2;
               end else if (prior_q) begin
                  take = 1'b1;
                  rw_d = 1'b1;
                  state_d = ST_TX;
               end else begin
                  state_d = ST_WAIT;
               end
            end
            ST_ADDR2: begin
               sw_hold = address_hold_enable;
               if (match_lo) begin
                  take = 1'b1;
                  prior_d = 1'b1;
                  state_d = ST_RX;
               end else begin
                  state_d = ST_WAIT;
               end
            end
            ST_RX: begin
               sw_hold = data_hold_enable;
               take = 1'b1;
            end
            ST_TX: begin
               want_d = 1'b0;
            end
            default: begin
               want_d = 1'b0;
            end
         endcase
         if (take) begin
            irq_set = 1'b1;
            if (room) begin
               load = 1'b1;
               rbuf_d = shift_q;
            end else begin
               ov_set = 1'b1;
            end
            if (sw_hold) begin
               acktm_d = 1'b1;
               stretch_d = 1'b1;
               ackpend_d = 1'b1;
               ackok_d = room;
            end else begin
               want_d = room;
            end
         end
      end

      if (ack_end) begin
         cnt_d = `RST_CNT;
         acktm_d = 1'b0;
         if (state_q == ST_TX) begin
            if (ackst_q) begin
               state_d = ST_WAIT;
               want_d = 1'b0;
            end else begin
               stretch_d = 1'b1;
            end
         end else begin
            if (!want_q) begin
               state_d = ST_WAIT;
            end
            want_d = 1'b0;
         end
      end

      if (clock_release && stretch_q) begin
         stretch_d = 1'b0;
         if (ackpend_q) begin
            ackpend_d = 1'b0;
            want_d = ackok_q & ~ack_data;
         end else if (state_q == ST_TX) begin
            tx_d = tx_data;
            want_d = ~tx_data[7];
         end
      end

      if (start_acc) begin
         if (state_q == ST_TX && tx_q[7] && cnt_q < `BIT_LAST) begin
            coll_set = 1'b1;
         end
         state_d = ST_ADDR;
         cnt_d = `RST_CNT;
         want_d = 1'b0;
         stretch_d = 1'b0;
         ackpend_d = 1'b0;
         acktm_d = 1'b0;
         active_d = 1'b1;
         low_d = 1'b0;
         sseen_d = 1'b1;
         pseen_d = 1'b0;
         irq_set = sp_irq | start_irq_enable;
      end

      if (stop_det) begin
         state_d = ST_IDLE;
         active_d = 1'b0;
         prior_d = 1'b0;
         want_d = 1'b0;
         stretch_d = 1'b0;
         ackpend_d = 1'b0;
         acktm_d = 1'b0;
         sseen_d = 1'b0;
         pseen_d = 1'b1;
         irq_set = sp_irq | stop_irq_enable;
      end

      if (!port_enable) begin
         state_d = ST_IDLE;
         cnt_d = `RST_CNT;
         active_d = 1'b0;
         want_d = 1'b0;
         stretch_d = 1'b0;
         ackpend_d = 1'b0;
         acktm_d = 1'b0;
         prior_d = 1'b0;
      end
   end

   // =======================================================================
   // Flags, hold timer and pin drive
   // A flag that sets in its clearing cycle stays set.
   always_comb begin
      bf_d = (bf_q & ~rx_read) | load;
      ov_d = (ov_q & ~overflow_clear) | ov_set;
      irq_d = (irq_q & ~irq_clear) | irq_set;
      coll_d = (coll_q & ~collision_clear) | coll_set;
      hold_d = hold_q;
      if (scl_fall) begin
         hold_d = hold_time_select ? `HOLD_CNT_W'(`HOLD_LONG_CYC)
                                   : `HOLD_CNT_W'(`HOLD_SHORT_CYC);
      end else if (hold_q != `HOLD_CNT_W'(0)) begin
         hold_d = hold_q - `HOLD_CNT_W'(1);
      end
      // While the port is enabled, SDA may only move once the hold window after SCL fall has passed.
      if (!port_enable) begin
         sda_oe_d = 1'b0;
      end else if (hold_q == `HOLD_CNT_W'(0)) begin
         sda_oe_d = want_q;
      end else begin
         sda_oe_d = sda_oe_q;
      end
      scl_oe_d = port_enable & stretch_q;
      sda_out_d = 1'b0;
      scl_out_d = 1'b0;
   end

   // =======================================================================
   // Registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         cnt_q <= `RST_CNT;
         shift_q <= `RST_BYTE;
         tx_q <= `RST_BYTE;
         rbuf_q <= `RST_BYTE;
         hold_q <= '0;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         low_q <= 1'b0;
         active_q <= 1'b0;
         sseen_q <= 1'b0;
         pseen_q <= 1'b0;
         want_q <= 1'b0;
         stretch_q <= 1'b0;
         ackpend_q <= 1'b0;
         ackok_q <= 1'b0;
         sda_oe_q <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_out_q <= 1'b0;
         scl_out_q <= 1'b0;
         bf_q <= 1'b0;
         ov_q <= 1'b0;
         irq_q <= 1'b0;
         ackst_q <= 1'b0;
         acktm_q <= 1'b0;
         rw_q <= 1'b0;
         prior_q <= 1'b0;
         coll_q <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         tx_q <= tx_d;
         rbuf_q <= rbuf_d;
         hold_q <= hold_d;
         scl_p_q <= scl_p_d;
         sda_p_q <= sda_p_d;
         low_q <= low_d;
         active_q <= active_d;
         sseen_q <= sseen_d;
         pseen_q <= pseen_d;
         want_q <= want_d;
         stretch_q <= stretch_d;
         ackpend_q <= ackpend_d;
         ackok_q <= ackok_d;
         sda_oe_q <= sda_oe_d;
         scl_oe_q <= scl_oe_d;
         sda_out_q <= sda_out_d;
         scl_out_q <= scl_out_d;
         bf_q <= bf_d;
         ov_q <= ov_d;
         irq_q <= irq_d;
         ackst_q <= ackst_d;
         acktm_q <= acktm_d;
         rw_q <= rw_d;
         prior_q <= prior_d;
         coll_q <= coll_d;
      end
   end

   assign scl_out = scl_out_q;
   assign scl_oe = scl_oe_q;
   assign sda_out = sda_out_q;
   assign sda_oe = sda_oe_q;
   assign receive_buffer = rbuf_q;
   assign buffer_full = bf_q;
   assign receive_overflow = ov_q;
   assign port_irq_flag = irq_q;
   assign ack_status = ackst_q;
   assign ack_time = acktm_q;
   assign rw_status = rw_q;
   assign prior_match = prior_q;
   assign bus_active = active_q;
   assign start_seen = sseen_q;
   assign stop_seen = pseen_q;
   assign bus_collision = coll_q;

   // =======================================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst || !clk_en);

   pins_released_a: assert property (
      !port_enable |=> ##1 (!sda_oe && !scl_oe))
      else $error("pins driven while port disabled");
   data_zero_a: assert property (
      ##1 (!sda_out && !scl_out))
      else $error("pin data not zero");
   hold_window_a: assert property (
      scl_fall && hold_time_select |=> $stable(sda_oe)[*8])
      else $error("sda moved inside hold window");
   start_active_a: assert property (
      start_acc |=> bus_active && start_seen && state_q == ST_ADDR)
      else $error("start did not activate bus");
   stop_idle_a: assert property (
      stop_det |=> !bus_active && stop_seen && state_q == ST_IDLE)
      else $error("stop did not idle bus");
   stop_low_a: assert property (
      $rose(stop_seen) |-> $past(low_q))
      else $error("stop accepted without scl low");
   collision_set_a: assert property (
      coll_set && !start_acc && port_enable
         |=> bus_collision && state_q == ST_WAIT)
      else $error("collision not flagged");
   prior_stop_a: assert property (
      stop_det |=> !prior_match)
      else $error("prior match survived stop");
   nack_full_a: assert property (
      byte_done && take && !room && !sw_hold |=> !want_q)
      else $error("acknowledged with buffer full");
   acktime_gate_a: assert property (
      $rose(ack_time) |-> $past(address_hold_enable)
                          || $past(data_hold_enable))
      else $error("ack time without hold enable");
   start_irq_a: assert property (
      start_acc && sp_irq |=> port_irq_flag)
      else $error("start irq missing");
   read_stretch_a: assert property (
      ack_end && state_q == ST_TX && !ackst_q |=> ##1 scl_oe)
      else $error("scl not held for transmit");

endmodule

`default_nettype wire

/* File: i2c_slave_params.svh */
`ifndef I2C_SLAVE_PARAMS_SVH
`define I2C_SLAVE_PARAMS_SVH

// ==========================================================================
// Mode field layout
`define MODE_TEN_BIT 0
`define MODE_SP_IRQ 1

// ==========================================================================
// Byte framing
`define BIT_LAST 4'h8
`define BIT_ACK 4'h9
`define TEN_PREFIX 5'h1E

// ==========================================================================
// Timing
`define CLK_PERIOD_NS 20
`define HOLD_LONG_NS 300
`define HOLD_SHORT_NS 100
`define HOLD_CNT_W 5
`define HOLD_LONG_CYC \
   ((`HOLD_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_SHORT_CYC \
   ((`HOLD_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================================================
// Reset values
`define RST_BYTE 8'h00
`define RST_CNT 4'h0

`endif

/* File: i2c_slave_pkg.sv */
`default_nettype none

package i2c_slave_pkg;

   // =======================================================================
   // Slave sequencing states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_ADDR2 = 3'b010,
      ST_RX    = 3'b011,
      ST_TX    = 3'b100,
      ST_WAIT  = 3'b101
   } state_t;

endpackage

`default_nettype wire

/* File: bit_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
   parameter int WIDTH = 2
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   // =======================================================================
   // Two stages per bit; the first stage feeds only the second.
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         logic meta_q;
         logic meta_d;
         logic sync_q;
         logic sync_d;
         always_comb begin
            meta_d = din[i];
            sync_d = meta_q;
         end
         always_ff @(posedge mclk) begin
            if (sys_rst) begin
               meta_q <= 1'b1;
               sync_q <= 1'b1;
            end else if (clk_en) begin
               meta_q <= meta_d;
               sync_q <= sync_d;
            end
         end
         assign dout[i] = sync_q;
      end
   endgenerate

endmodule

`default_nettype wire

/* File: i2c_master_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Bus master on the far side; lines are open-drain, so it only pulls low.
module i2c_master_model (
   input wire logic mclk,
   input wire logic scl,
   input wire logic sda,
   output logic scl_oe,
   output logic sda_oe
);
   // Low phase is longer than the 120 ns high phase so the long hold fits in it.
   localparam int LO = 28;
   localparam int HI = 6;

   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // The slave may stretch, so wait for the line, but never for ever.
   task automatic wait_high();
      int k;
      k = 0;
      scl_oe = 1'b0;
      while (!scl && k < 5000) begin
         tick(1);
         k++;
      end
   endtask

   task automatic cond_start();
      if (scl_oe) begin
         sda_oe = 1'b0;
         tick(LO);
         wait_high();
         tick(HI);
      end
      sda_oe = 1'b1;
      tick(HI);
      scl_oe = 1'b1;
      tick(6);
   endtask

   task automatic cond_stop();
      tick(6);
      sda_oe = 1'b1;
      tick(LO);
      wait_high();
      tick(HI);
      sda_oe = 1'b0;
      tick(2 * HI);
   endtask

   // Start and stop inside one SCL high window.
   task automatic glitch();
      sda_oe = 1'b1;
      tick(HI);
      sda_oe = 1'b0;
      tick(HI);
      scl_oe = 1'b1;
      tick(6);
   endtask

   // Nine bits MSB first; a one releases SDA, as in the ack slot.
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         tick(6);
         sda_oe = !tx[i];
         tick(LO - 6);
         wait_high();
         tick(2);
         rx[i] = sda;
         tick(HI - 2);
         scl_oe = 1'b1;
      end
   endtask
endmodule

`default_nettype wire

/* File: i2c_slave_bus_condition_ack_bench.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Bench
module i2c_slave_bus_condition_ack_bench;
   typedef struct {
      logic [1:0] mode;
      logic sie;
      logic [7:0] addr;
      logic ack;
      logic irq;
   } row_t;
   row_t rows[8] = '{
      '{2'h0, 1'b0, 8'hA4, 1'b0, 1'b0}, '{2'h0, 1'b0, 8'hA6, 1'b1, 1'b0},
      '{2'h2, 1'b0, 8'hA6, 1'b1, 1'b1}, '{2'h0, 1'b1, 8'hA6, 1'b1, 1'b1},
      '{2'h3, 1'b1, 8'hA2, 1'b1, 1'b1}, '{2'h1, 1'b0, 8'hF4, 1'b0, 1'b0},
      '{2'h1, 1'b0, 8'hF6, 1'b1, 1'b0}, '{2'h1, 1'b0, 8'hA4, 1'b1, 1'b0}};
   logic mclk, sys_rst, port_enable, hold_time_select, start_irq_enable;
   logic address_hold_enable, ack_data, clock_release, rx_read, irq_clear;
   logic overflow_clear, collision_clear, auto_rel, saw_at;
   logic [1:0] slave_mode_select;
   logic [7:0] tx_data, receive_buffer;
   logic [8:0] got;
   logic scl_out, scl_oe, sda_out, sda_oe, m_scl_oe, m_sda_oe;
   logic buffer_full, receive_overflow, port_irq_flag, ack_status, ack_time;
   logic rw_status, prior_match, bus_active, start_seen, stop_seen;
   logic bus_collision, clk_en, stop_irq_enable, data_hold_enable;
   int miscompares = 0;
   int check_count = 0;
   int rel_cnt = 0;
   real t_fall = 0.0;
   wire scl_line = !(scl_oe | m_scl_oe);
   wire sda_line = !(sda_oe | m_sda_oe);

   i2c_slave_bus dut_u (.mclk, .sys_rst, .clk_en, .scl_in(scl_line),
      .sda_in(sda_line), .scl_out, .scl_oe, .sda_out, .sda_oe, .port_enable,
      .slave_mode_select, .hold_time_select, .start_irq_enable,
      .stop_irq_enable, .address_hold_enable, .data_hold_enable,
      .ack_data, .own_address(8'hA4), .own_address_low(8'h3B), .tx_data,
      .clock_release, .rx_read, .irq_clear, .overflow_clear,
      .collision_clear, .receive_buffer, .buffer_full, .receive_overflow,
      .port_irq_flag, .ack_status, .ack_time, .rw_status, .prior_match,
      .bus_active, .start_seen, .stop_seen, .bus_collision);
   i2c_master_model bus_master (.mclk, .scl(scl_line), .sda(sda_line),
      .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

   always #10 mclk = ~mclk;

   // Software side: release a stretched clock after a short delay.
   always @(negedge mclk) begin
      rel_cnt <= (auto_rel && scl_oe) ? rel_cnt + 1 : 0;
      clock_release <= (rel_cnt == 4);
   end
   always @(posedge mclk) if (ack_time) saw_at <= 1'b1;
   always @(negedge scl_line) t_fall = $realtime;
   always @(sda_oe) begin
      if (!sys_rst) begin
         chk($realtime - t_fall >= (hold_time_select ? 300.0 : 100.0), 1);
         chk(sda_out | scl_out, 1'b0);
      end
   end

   task automatic chk(input logic g, input logic e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %0t bit got %b expected %b", $time, g, e);
      end
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %0t byte got %h expected %h", $time, g, e);
      end
   endtask
   task automatic clr();
      {irq_clear, rx_read, overflow_clear, collision_clear} = 4'hF;
      @(negedge mclk);
      {irq_clear, rx_read, overflow_clear, collision_clear} = 4'h0;
   endtask
   task automatic close_out();
      if (miscompares == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // The whole sequence needs about 9000 cycles.
   initial begin
      repeat (60000) @(posedge mclk);
      miscompares++;
      close_out();
   end

   initial begin
      {mclk, sys_rst, port_enable, auto_rel, saw_at, clk_en} = 6'b011001;
      {hold_time_select, start_irq_enable, address_hold_enable} = 3'h0;
      {stop_irq_enable, data_hold_enable} = 2'h0;
      {ack_data, clock_release, rx_read, irq_clear} = 4'h0;
      {overflow_clear, collision_clear, slave_mode_select} = 4'h0;
      tx_data = 8'h96;
      repeat (8) @(negedge mclk);
      chk(bus_active, 1'b0);
      chk(port_irq_flag, 1'b0);
      chk(sda_oe | scl_oe, 1'b0);
      sys_rst = 1'b0;
      foreach (rows[i]) begin
         slave_mode_select = rows[i].mode;
         start_irq_enable = rows[i].sie;
         clr();
         bus_master.cond_start();
         chk(start_seen, 1'b1);
         chk(bus_active, 1'b1);
         chk(port_irq_flag, rows[i].irq);
         bus_master.xfer({rows[i].addr, 1'b1}, got);
         chk(got[0], rows[i].ack);
         chk(ack_status, rows[i].ack);
         if (!rows[i].ack) begin
            chk8(receive_buffer, rows[i].addr);
            chk(buffer_full & port_irq_flag, 1'b1);
         end
         bus_master.cond_stop();
         chk(stop_seen, 1'b1);
         chk(bus_active, 1'b0);
      end
      {slave_mode_select, start_irq_enable} = 3'h0;
      clr();
      chk(saw_at, 1'b0);
      bus_master.cond_start();
      bus_master.xfer({8'hA4, 1'b1}, got);
      clr();
      bus_master.xfer({8'h3C, 1'b1}, got);
      chk(got[0], 1'b0);
      chk8(receive_buffer, 8'h3C);
      bus_master.xfer({8'h5A, 1'b1}, got);
      chk(got[0], 1'b1);
      chk(receive_overflow, 1'b1);
      bus_master.cond_stop();
      {address_hold_enable, data_hold_enable, auto_rel} = 3'b111;
      for (int a = 0; a < 2; a++) begin
         ack_data = a[0];
         saw_at = 1'b0;
         clr();
         bus_master.cond_start();
         bus_master.xfer({8'hA4, 1'b1}, got);
         chk(got[0], a[0]);
         clr();
         bus_master.xfer({8'h3C, 1'b1}, got);
         chk(got[0], a[0]);
         chk(saw_at, 1'b1);
         // The acknowledge-time bit drops only once the ninth fall is seen.
         repeat (4) @(negedge mclk);
         chk(ack_time, 1'b0);
         bus_master.cond_stop();
      end
      {address_hold_enable, data_hold_enable, hold_time_select} = 3'b001;
      for (int k = 0; k < 3; k++) begin
         clr();
         bus_master.cond_start();
         bus_master.xfer({8'hA5, 1'b1}, got);
         chk(got[0], 1'b0);
         chk(rw_status, 1'b1);
         if (k == 2) begin
            bus_master.cond_start();
            chk(bus_collision, 1'b1);
         end else if (k == 1) begin
            bus_master.xfer(9'h001, got);
            chk(bus_collision, 1'b1);
         end else begin
            bus_master.xfer(9'h1FF, got);
            chk8(got[8:1], 8'h96);
            chk(ack_status, 1'b1);
         end
         bus_master.cond_stop();
      end
      {slave_mode_select, hold_time_select} = 3'b010;
      clr();
      bus_master.cond_start();
      bus_master.xfer({8'hF4, 1'b1}, got);
      clr();
      bus_master.xfer({8'h3B, 1'b1}, got);
      chk(got[0], 1'b0);
      chk(prior_match, 1'b1);
      clr();
      start_irq_enable = 1'b1;
      bus_master.cond_start();
      chk(start_seen & port_irq_flag, 1'b1);
      bus_master.xfer({8'hF5, 1'b1}, got);
      chk(got[0] | !rw_status, 1'b0);
      bus_master.xfer(9'h1FF, got);
      chk8(got[8:1], 8'h96);
      bus_master.cond_stop();
      chk(prior_match, 1'b0);
      bus_master.glitch();
      chk(bus_active & start_seen, 1'b1);
      stop_irq_enable = 1'b1;
      clr();
      bus_master.cond_stop();
      chk(port_irq_flag, 1'b1);
      // A disabled or frozen port must ignore a whole bus frame.
      for (int j = 0; j < 2; j++) begin
         {port_enable, clk_en} = j ? 2'b10 : 2'b01;
         bus_master.cond_start();
         chk(bus_active | sda_oe | scl_oe, 1'b0);
         bus_master.cond_stop();
      end
      {port_enable, clk_en} = 2'b11;
      bus_master.cond_start();
      sys_rst = 1'b1;
      repeat (2) @(negedge mclk);
      sys_rst = 1'b0;
      chk(bus_active | start_seen | sda_oe, 1'b0);
      bus_master.cond_stop();
      chk(stop_seen, 1'b0);
      close_out();
   end
endmodule

`default_nettype wire
